// *** tecnt_consts.vh ***
// Constants for the 16-bit timer/event counter block.
// Assumes inclusion by tecnt_top.v only.
`ifndef TECNT_CONSTS_VH
`define TECNT_CONSTS_VH

// Register byte addresses
`define TECNT_ADDR_COUNT_LOW 4'h0
`define TECNT_ADDR_COUNT_HIGH 4'h4
`define TECNT_ADDR_CONTROL 4'h8
`define TECNT_ADDR_IRQ 4'hC
`define TECNT_ADDR_W 4

// Control register fields
`define TECNT_CTRL_HI_BIT 7
`define TECNT_CTRL_LO_BIT 6
`define TECNT_CTRL_RUN_BIT 4
`define TECNT_CTRL_EDGE_BIT 3
`define TECNT_CTRL_RESET 8'h00

// Interrupt control register fields
`define TECNT_IRQ_EN_BIT 0
`define TECNT_IRQ_FLAG_BIT 1

// Timing
`define TECNT_PRESCALE 2'h3
`define TECNT_FULL 16'hFFFF
`define TECNT_ZERO16 16'h0000
`define TECNT_ZERO8 8'h00

// Bus responses
`define TECNT_RESP_OKAY 2'h0
`define TECNT_RESP_SLVERR 2'h2

`endif

// *** tecnt_top.v ***
// 16-bit count-up timer/event counter with AXI4-Lite register access.
// Assumes timer_input_pin asynchronous to aclk; power_down from the core.
//
// Function
// RL1: Mode 01 counts pin edges while running
// RL2: Edge select low rising, high falling
// RL3: Overflow reloads preload, counting continues
// RL4: Overflow sets flag; irq only if enabled
// RL5: Event counting continues during power-down
// RL6: Overflow never wakes the core
// RL7: Mode 11 counts internal divided clock
// RL8: Edge low: falling starts, high stops
// RL9: Edge high: rising starts, low stops
// RL10: Timer and event modes never self-clear run
// RL11: After auto stop, ignore pin until rerun
// RL12: Software selects mode and input direction
// RL13: Pull-high option kept while timer input
// RL14: Pin seen only at next timer tick
// RL15: Counting inhibited during counter read, preload write
// RL16: Run bit is control bit 4
// RL17: Software sets run after mode bits
// RL18: Software loads value before running
// RL19: Mode 10 counts system clock over four
// RL20: Overflow past FFFF; stopped preload loads counter
// RL21: Low byte buffered; high read latches low
// RL22: Pin passes two-stage synchroniser
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "tecnt_consts.vh"

module tecnt_top (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire timer_input_pin,
    input wire pull_high_option,
    input wire power_down,
    output reg timer_pin_pull_high,
    output reg timer_irq
);

    // Modes
    localparam [2:0] MODE_OFF = 3'b001;
    localparam [2:0] MODE_TIMER = 3'b010;
    localparam [2:0] MODE_EVENT = 3'b100;

    reg [7:0] control;
    reg timer_irq_enable;
    reg irq_flag;
    reg [15:0] count;
    reg [15:0] preload;
    reg [7:0] low_buffer;
    reg [7:0] low_latch;
    reg pin_meta;
    reg pin_sync;
    reg pin_prev;
    reg pw_active;
    reg [1:0] prescale;
    reg [3:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;

    wire mode_select_hi = control[`TECNT_CTRL_HI_BIT];
    wire mode_select_lo = control[`TECNT_CTRL_LO_BIT];
    wire count_run = control[`TECNT_CTRL_RUN_BIT];
    wire edge_select = control[`TECNT_CTRL_EDGE_BIT];
    wire pw_mode = mode_select_hi & mode_select_lo;

    // Mode decode, used by the counting logic only
    function [2:0] mode_of;
        input hi;
        input lo;
        begin
            case ({hi, lo})
                2'b10: mode_of = MODE_TIMER;
                2'b01: mode_of = MODE_EVENT;
                2'b11: mode_of = MODE_TIMER;
                default: mode_of = MODE_OFF;
            endcase
        end
    endfunction

    wire [2:0] mode = mode_of(mode_select_hi, mode_select_lo);

    // Bus write and read decode
    wire wr_go = aw_held & w_held & ~s_axi_bvalid;
    wire wr_low = wr_go & (aw_addr == `TECNT_ADDR_COUNT_LOW) & w_strb[0];
    wire wr_high = wr_go & (aw_addr == `TECNT_ADDR_COUNT_HIGH) & w_strb[0];
    wire wr_ctrl = wr_go & (aw_addr == `TECNT_ADDR_CONTROL) & w_strb[0];
    wire wr_irq = wr_go & (aw_addr == `TECNT_ADDR_IRQ) & w_strb[0];
    wire rd_go = s_axi_arvalid & s_axi_arready;
    wire rd_count = rd_go & ((s_axi_araddr == `TECNT_ADDR_COUNT_LOW) |
        (s_axi_araddr == `TECNT_ADDR_COUNT_HIGH));

    // Edge and level of the synchronised pin
    wire pin_rise = pin_sync & ~pin_prev;
    wire pin_fall = ~pin_sync & pin_prev;
    wire active_edge = edge_select ? pin_fall : pin_rise; // RL2
    wire start_edge = edge_select ? pin_rise : pin_fall;
    wire pw_idle_level = edge_select ? 1'b0 : 1'b1;

    // Internal tick is system clock over four
    wire tick = (prescale == `TECNT_PRESCALE); // RL19

    // Counting clock gated by bus access to counter
    wire inhibit = rd_count | wr_high; // RL15

    reg next_inc;
    reg next_pw_stop;
    always @* begin
        next_inc = 1'b0;
        next_pw_stop = 1'b0;
        if (count_run && !inhibit) begin
            case (mode)
                MODE_EVENT: next_inc = active_edge; // RL1 RL5
                MODE_TIMER: begin
                    if (!pw_mode) begin
                        next_inc = tick; // RL19
                    end else if (pw_active && tick) begin
                        // Pin sampled only on timer ticks
                        if (pin_sync == pw_idle_level) begin // RL14
                            next_pw_stop = 1'b1; // RL8 RL9
                        end else begin
                            next_inc = 1'b1; // RL7
                        end
                    end
                end
                default: next_inc = 1'b0;
            endcase
        end
    end

    wire overflow = next_inc & (count == `TECNT_FULL); // RL20

    // Synchroniser for the asynchronous pin
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end else begin
            pin_meta <= timer_input_pin; // RL22
            pin_sync <= pin_meta; // RL22
            pin_prev <= pin_sync;
        end
    end

    // Prescaler free-runs
    always @(posedge aclk) begin
        if (!aresetn) begin
            prescale <= 2'h0;
        end else begin
            prescale <= prescale + 2'h1;
        end
    end

    // Pulse width arm: start edge opens measurement
    always @(posedge aclk) begin
        if (!aresetn) begin
            pw_active <= 1'b0;
        end else if (!pw_mode || !count_run || next_pw_stop) begin
            pw_active <= 1'b0; // RL11
        end else if (start_edge) begin
            pw_active <= 1'b1; // RL8 RL9
        end
    end

    // Control register; only pulse width mode self-clears run
    always @(posedge aclk) begin
        if (!aresetn) begin
            control <= `TECNT_CTRL_RESET;
        end else if (wr_ctrl) begin
            control <= w_data[7:0]; // RL16
        end else if (next_pw_stop) begin
            control[`TECNT_CTRL_RUN_BIT] <= 1'b0; // RL8 RL9 RL10
        end
    end

    // Interrupt control: set wins over software clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_irq_enable <= 1'b0;
            irq_flag <= 1'b0;
        end else begin
            if (wr_irq) begin
                timer_irq_enable <= w_data[`TECNT_IRQ_EN_BIT];
            end
            if (overflow) begin
                irq_flag <= 1'b1; // RL4
            end else if (wr_irq) begin
                irq_flag <= w_data[`TECNT_IRQ_FLAG_BIT];
            end
        end
    end

    // Irq independent of power_down, no wake output
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_irq <= 1'b0;
            timer_pin_pull_high <= 1'b0;
        end else begin
            timer_irq <= irq_flag & timer_irq_enable; // RL4 RL6
            timer_pin_pull_high <= pull_high_option; // RL13
        end
    end

    // Preload, low buffer and counter
    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= `TECNT_ZERO16;
            preload <= `TECNT_ZERO16;
            low_buffer <= `TECNT_ZERO8;
        end else begin
            if (wr_low) begin
                low_buffer <= w_data[7:0]; // RL21
            end
            if (wr_high) begin
                preload <= {w_data[7:0], low_buffer}; // RL21
            end
            if (wr_high && !count_run) begin
                count <= {w_data[7:0], low_buffer}; // RL20
            end else if (overflow) begin
                count <= preload; // RL3
            end else if (next_inc) begin
                count <= count + 16'h0001;
            end
        end
    end

    // AXI write channel capture
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TECNT_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready;
            s_axi_wready <= ~w_held & ~s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr[1:0] != 2'h0) ?
                    `TECNT_RESP_SLVERR : `TECNT_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // AXI read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TECNT_RESP_OKAY;
            low_latch <= `TECNT_ZERO8;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `TECNT_RESP_OKAY;
                case (s_axi_araddr)
                    `TECNT_ADDR_COUNT_LOW:
                        s_axi_rdata <= {24'h000000, low_latch}; // RL21
                    `TECNT_ADDR_COUNT_HIGH: begin
                        s_axi_rdata <= {24'h000000, count[15:8]};
                        low_latch <= count[7:0]; // RL21
                    end
                    `TECNT_ADDR_CONTROL:
                        s_axi_rdata <= {24'h000000, control};
                    `TECNT_ADDR_IRQ:
                        s_axi_rdata <= {30'h00000000, irq_flag,
                            timer_irq_enable};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `TECNT_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// *** tecnt_props.sv ***
// Checker for the timer/event counter bus handshakes and the pull-high pin output.
// Assumes binding to tecnt_top; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tecnt_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pull_high_option,
    input wire logic timer_pin_pull_high
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_ok;
        rd_take ##0 s_axi_araddr[1:0] == 2'h0;
    endsequence
    sequence rd_bad;
        rd_take ##0 s_axi_araddr[1:0] != 2'h0;
    endsequence
    a_pull_high_kept: assert property (
        $past(aresetn) |-> timer_pin_pull_high == $past(pull_high_option))
        else $error("pull-high output not following option");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_error: assert property (
        rd_bad |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unaligned read not refused");
    a_read_okay: assert property (rd_ok |=> s_axi_rresp == 2'h0)
        else $error("aligned read refused");
    a_rdata_done: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after handshake");
    a_bresp_done: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after handshake");
endmodule
bind tecnt_top tecnt_props u_props (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pull_high_option(pull_high_option),
    .timer_pin_pull_high(timer_pin_pull_high));
`default_nettype wire

// *** tecnt_pin_src.sv ***
// Outside pulse and event source on the timer input pin.
// Assumes the bench calls level() from its main sequence.
`timescale 1ns/10ps
`default_nettype none
module tecnt_pin_src (
    input wire logic aclk,
    output logic pin
);
    initial pin = 1'b1;
    // Level changes on the clock edge, then holds n clocks
    task automatic level(input logic v, input int n);
        @(posedge aclk);
        pin <= v;
        repeat (n) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// *** tecnt_top_tb.sv ***
// Testbench for the timer/event counter: bus tasks, one task a scenario.
// Assumes tecnt_top, the bound checker and the pin source model.
`timescale 1ns/10ps
`default_nettype none
module tecnt_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, pull_high_option, power_down;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, timer_pin_pull_high, timer_irq, pin;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [1:0] s_axi_bresp, s_axi_rresp, bresp_q, rresp_q;
    logic [15:0] cnt;
    int fails = 0;
    int n_checks = 0;
    tecnt_top u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .timer_input_pin(pin),
        .pull_high_option(pull_high_option), .power_down(power_down),
        .timer_pin_pull_high(timer_pin_pull_high), .timer_irq(timer_irq));
    tecnt_pin_src u_src (.aclk(aclk), .pin(pin));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tmo;
        fails++;
        $display("CHECK FAILED %0t timeout", $time);
        give_verdict;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w;
        int i;
        {aw, w} = 2'b11;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) break;
        end
        if (i == 64) tmo;
        bresp_q = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a);
        logic ar;
        int i;
        ar = 1'b1;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) break;
        end
        if (i == 64) tmo;
        {rdat, rresp_q} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rdcnt;
        rd(4'h4);
        cnt[15:8] = rdat[7:0];
        rd(4'h0);
        cnt[7:0] = rdat[7:0];
    endtask
    task automatic load(input logic [15:0] v);
        wr(4'h0, {24'h0, v[7:0]});
        wr(4'h4, {24'h0, v[15:8]});
    endtask
    task automatic run(input logic [7:0] m);
        wr(4'h8, {24'h0, m});
        wr(4'h8, {24'h0, m | 8'h10});
    endtask
    task automatic t_regs;
        rd(4'h8);
        chk(rdat, 32'h0);
        rd(4'h1);
        chk({30'h0, rresp_q}, 32'h2);
        wr(4'h2, 32'h0);
        chk({30'h0, bresp_q}, 32'h2);
        pull_high_option <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({31'h0, timer_pin_pull_high}, 32'h1);
    endtask
    task automatic t_rate;
        load(16'h0000);
        run(8'h80);
        repeat (40) @(posedge aclk);
        wr(4'h8, 32'h80);
        rdcnt;
        chk(32'(cnt >= 16'h000A && cnt <= 16'h000D), 32'h1);
    endtask
    task automatic t_ovf;
        int i;
        load(16'hFFFE);
        rdcnt;
        chk({16'h0, cnt}, 32'hFFFE);
        wr(4'hC, 32'h1);
        run(8'h80);
        for (i = 0; i < 100 && timer_irq !== 1'b1; i++) @(posedge aclk);
        if (i == 100) tmo;
        rd(4'hC);
        chk(rdat, 32'h3);
        rd(4'h4);
        chk(rdat, 32'hFF);
        rd(4'h8);
        chk(rdat, 32'h90);
        load(16'h1200);
        repeat (20) @(posedge aclk);
        rd(4'h4);
        chk(rdat, 32'h12);
        wr(4'hC, 32'h2);
        repeat (3) @(posedge aclk);
        chk({31'h0, timer_irq}, 32'h0);
        wr(4'h8, 32'h80);
        wr(4'hC, 32'h0);
        rd(4'hC);
        chk(rdat, 32'h0);
    endtask
    task automatic t_event;
        power_down <= 1'b1;
        load(16'h0000);
        run(8'h40);
        repeat (10) u_src.level(~pin, 6);
        rdcnt;
        chk({16'h0, cnt}, 32'h5);
        rd(4'h8);
        chk(rdat, 32'h50);
        wr(4'h8, 32'h48);
        load(16'h0000);
        run(8'h48);
        repeat (6) u_src.level(~pin, 6);
        rdcnt;
        chk({16'h0, cnt}, 32'h3);
        wr(4'h8, 32'h48);
        power_down <= 1'b0;
    endtask
    task automatic t_pulse(input logic [7:0] m);
        logic [15:0] w;
        u_src.level(~m[3], 4);
        load(16'h0000);
        run(m);
        u_src.level(m[3], 40);
        u_src.level(~m[3], 8);
        rd(4'h8);
        chk(rdat, {24'h0, m});
        rdcnt;
        chk(32'(cnt >= 16'h0009 && cnt <= 16'h000B), 32'h1);
        w = cnt;
        u_src.level(m[3], 40);
        u_src.level(~m[3], 8);
        rdcnt;
        chk({16'h0, cnt}, {16'h0, w});
    endtask
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready} = 2'b00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h00F;
        s_axi_wdata = 32'h0;
        {pull_high_option, power_down} = 2'b00;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_rate;
        t_ovf;
        t_event;
        t_pulse(8'hC0);
        t_pulse(8'hC8);
        give_verdict;
    end
endmodule
`default_nettype wire
